// file: sim/slot_host.sv
// far-end receiver model: makes the link clock and frame sync, samples both data lines
module slot_host (
	// link clock and frame
	output logic      bclk_o,
	output logic      fsync_o,
	// data lines from the block
	input  wire logic pri_data_i,
	input  wire logic pri_oe_n_i,
	input  wire logic sec_data_i,
	input  wire logic sec_oe_n_i
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// line level and capture
	// ----------------------------------------
	// a released line floats, so an undriven bit is seen as z
	wire  pri_line = pri_oe_n_i ? 1'bz : pri_data_i;
	wire  sec_line = sec_oe_n_i ? 1'bz : sec_data_i;
	logic pri_cap [0:79];
	logic sec_cap [0:79];

	initial begin
		bclk_o = 1'b0;
		fsync_o = 1'b0;
	end

	// one frame of 80 bit clocks, 40 per half; the clock stands still between frames
	task run_frame(input logic [1:0] fmt);
		// a leading bit at the opposite level makes the first frame edge visible;
		// left-justified frames follow on without it so every half stays 40 bits long
		if (fmt != 2'h2) begin
			fsync_o = (fmt == 2'h1);
			#32 bclk_o = 1'b1;
			#32 bclk_o = 1'b0;
		end
		for (int i = 0; i < 80; i++) begin
			fsync_o = (fmt == 2'h1) ? (i >= 40) : ((fmt == 2'h2) ? (i < 40) : (i == 0));
			#32 bclk_o = 1'b1;
			pri_cap[i] = pri_line;
			sec_cap[i] = sec_line;
			#32 bclk_o = 1'b0;
		end
	endtask : run_frame
endmodule : slot_host

// file: sim/test_secondary_audio_tx_slot_map.sv
// self-checking bench for the second port slot mapping block
module test_secondary_audio_tx_slot_map;
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, sample_data_i = 32'h0;
	logic        sample_valid_i = 1'b0, sample_ready_o;
	logic        bclk, fsync, pri_d, pri_oe_n, sec_d, sec_oe_n;
	int          err_count = 0, n_tests = 0, cyc_cnt = 0;

	always #2.5 clk_i = ~clk_i;

	secondary_audio_tx_slot_map #(.SW(32), .FIFO_DEPTH(16)) i_secondary_audio_tx_slot_map (
		.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .sample_data_i, .sample_valid_i, .sample_ready_o,
		.bclk_i(bclk), .fsync_i(fsync), .primary_data_out_o(pri_d),
		.primary_data_oe_n_o(pri_oe_n), .secondary_data_out_o(sec_d),
		.secondary_data_oe_n_o(sec_oe_n));

	slot_host i_slot_host (.bclk_o(bclk), .fsync_o(fsync), .pri_data_i(pri_d),
		.pri_oe_n_i(pri_oe_n), .sec_data_i(sec_d), .sec_oe_n_i(sec_oe_n));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	function automatic logic [31:0] word(input int k);
		return 32'hC3A5_0F1E + 32'(k) * 32'h1111_1111;
	endfunction : word

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task chk_bit(input logic got, input logic exp, input int pos);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t: line bit %0d got %b expected %b", $time, pos, got, exp);
		end
	endtask : chk_bit

	// classic single cycle; read data lands in rd
	task wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'hF;
		wb_dat_i <= wd;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb

	task end_sim;
		if (err_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim

	// configure, run one frame, compare both lines bit by bit
	task t_frame(input logic [1:0] fmt, input logic [1:0] wl, input logic [4:0] off,
		input logic [4:0] slot, input logic rt, input logic en, input int pos,
		input logic [31:0] w);
		int   len;
		logic b;
		len = (wl == 2'h3) ? 32 : 16 + 4 * wl;
		wb(1'h1, 8'h68, {24'h0, fmt, wl, 4'h0});
		wb(1'h1, 8'h70, {27'h0, off});
		wb(1'h1, 8'h74, {31'h0, rt});
		wb(1'h1, 8'h78, {26'h0, en, slot});
		i_slot_host.run_frame(fmt);
		for (int i = 0; i < 80; i++) begin
			b = (pos >= 0 && i >= pos && i < pos + len) ? w[31 - (i - pos)] : 1'bz;
			chk_bit(i_slot_host.pri_cap[i], rt ? 1'bz : b, i);
			chk_bit(i_slot_host.sec_cap[i], rt ? b : 1'bz, i);
		end
	endtask : t_frame

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_regs;
		// status after reset: link idle, no underrun, empty buffer
		wb(1'h0, 8'hC0, 32'h0);
		chk(rd, 32'h0);
		wb(1'h0, 8'h68, 32'h0);
		chk(rd, 32'h30);
		wb(1'h0, 8'h70, 32'h0);
		chk(rd, 32'h0);
		wb(1'h0, 8'h74, 32'h0);
		chk(rd, 32'h0);
		wb(1'h0, 8'h78, 32'h0);
		chk(rd, 32'h0);
		wb(1'h1, 8'h74, 32'hA5);
		wb(1'h0, 8'h74, 32'h0);
		chk(rd, 32'hA5);
		wb(1'h1, 8'h68, 32'h90);
		wb(1'h0, 8'h68, 32'h0);
		chk(rd, 32'h90);
		// unmapped place: write ignored, reads zero
		wb(1'h1, 8'hFC, 32'hFF);
		wb(1'h0, 8'hFC, 32'h0);
		chk(rd, 32'h0);
	endtask : t_regs

	task t_idle;
		t_frame(2'h0, 2'h0, 5'h00, 5'h00, 1'h0, 1'h0, -1, 32'h0);
		t_frame(2'h3, 2'h0, 5'h00, 5'h00, 1'h0, 1'h1, -1, 32'h0);
	endtask : t_idle

	task t_fill;
		@(posedge clk_i);
		for (int k = 0; k < 16; k++) begin
			sample_data_i <= word(k);
			sample_valid_i <= 1'h1;
			@(posedge clk_i);
			chk_bit(sample_ready_o, 1'h1, k);
		end
		sample_data_i <= word(16);
		@(posedge clk_i);
		chk_bit(sample_ready_o, 1'h0, 16);
		sample_valid_i <= 1'h0;
		wb(1'h0, 8'hC0, 32'h0);
		chk(rd & 32'hFA, 32'h80);
	endtask : t_fill

	task t_tdm;
		t_frame(2'h0, 2'h0, 5'h00, 5'h00, 1'h0, 1'h1, 1, word(0));
		t_frame(2'h0, 2'h0, 5'h03, 5'h00, 1'h1, 1'h1, 4, word(1));
		t_frame(2'h0, 2'h0, 5'h1F, 5'h00, 1'h0, 1'h1, 32, word(2));
		t_frame(2'h0, 2'h0, 5'h00, 5'h02, 1'h0, 1'h1, 33, word(3));
		t_frame(2'h0, 2'h1, 5'h00, 5'h01, 1'h1, 1'h1, 21, word(4));
		t_frame(2'h0, 2'h2, 5'h00, 5'h01, 1'h0, 1'h1, 25, word(5));
		t_frame(2'h0, 2'h3, 5'h00, 5'h01, 1'h1, 1'h1, 33, word(6));
	endtask : t_tdm

	task t_i2s;
		t_frame(2'h1, 2'h0, 5'h00, 5'h00, 1'h0, 1'h1, 1, word(7));
		t_frame(2'h1, 2'h0, 5'h00, 5'h01, 1'h1, 1'h1, 17, word(8));
		t_frame(2'h1, 2'h0, 5'h00, 5'h10, 1'h0, 1'h1, 41, word(9));
		t_frame(2'h1, 2'h0, 5'h00, 5'h11, 1'h1, 1'h1, 57, word(10));
		t_frame(2'h1, 2'h0, 5'h02, 5'h10, 1'h0, 1'h1, 43, word(11));
		wb(1'h0, 8'hC0, 32'h0);
		chk(rd & 32'hF9, 32'h21);
	endtask : t_i2s

	// left-justified: first frame learns the half length, second sends right slot 0
	task t_lj;
		t_frame(2'h2, 2'h0, 5'h00, 5'h10, 1'h0, 1'h1, -1, 32'h0);
		t_frame(2'h2, 2'h0, 5'h00, 5'h10, 1'h1, 1'h1, 40, word(12));
	endtask : t_lj

	// drain to empty, then an empty buffer sends zeros and flags underrun
	task t_drain;
		for (int k = 13; k < 16; k++) begin
			t_frame(2'h0, 2'h0, 5'h00, 5'h00, 1'h0, 1'h1, 1, word(k));
		end
		t_frame(2'h0, 2'h0, 5'h00, 5'h00, 1'h0, 1'h1, 1, 32'h0);
		wb(1'h0, 8'hC0, 32'h0);
		chk(rd & 32'hFA, 32'h2);
		wb(1'h1, 8'hC0, 32'h2);
		wb(1'h0, 8'hC0, 32'h0);
		chk(rd & 32'hFA, 32'h0);
	endtask : t_drain

	// ----------------------------------------
	// main sequence and timeout
	// ----------------------------------------
	always @(posedge clk_i) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 40000) begin
			err_count++;
			end_sim();
		end
	end

	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_idle();
		t_fill();
		t_tdm();
		t_i2s();
		t_lj();
		t_drain();
		end_sim();
	end
endmodule : test_secondary_audio_tx_slot_map

// file: src/sample_fifo.sv
// sample buffer with registered read data
module sample_fifo #(
	parameter int W     = 32,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// streams
	sample_stream_if.snk            push,
	sample_stream_if.src            pop,
	// fill level
	output logic [$clog2(DEPTH):0]  level_o
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
	logic [AW:0]   cnt_r, cnt_nxt;
	logic [W-1:0]  rdata_r;
	logic          settle_r, settle_nxt;
	logic          do_push, do_pop;

	// read data lags the pointer by one cycle, so valid waits for it
	assign push.ready = (cnt_r != (AW+1)'(DEPTH));
	assign pop.valid  = settle_r && (cnt_r != '0);
	assign pop.data   = rdata_r;
	assign level_o    = cnt_r;
	assign do_push    = push.valid && push.ready;
	assign do_pop     = pop.valid && pop.ready;

	always_comb begin
		wr_nxt     = do_push ? wr_r + 1'b1 : wr_r;
		rd_nxt     = do_pop ? rd_r + 1'b1 : rd_r;
		cnt_nxt    = cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
		settle_nxt = !do_pop && (cnt_r != '0);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_r     <= '0;
			rd_r     <= '0;
			cnt_r    <= '0;
			settle_r <= 1'b0;
		end else begin
			wr_r     <= wr_nxt;
			rd_r     <= rd_nxt;
			cnt_r    <= cnt_nxt;
			settle_r <= settle_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (do_push) begin
			mem[wr_r] <= push.data;
		end
		rdata_r <= mem[rd_r];
	end
endmodule : sample_fifo

// file: src/sample_stream_if.sv
// valid/ready word stream between the block and its sample buffer
interface sample_stream_if #(parameter int W = 32) ();
	logic [W-1:0] data;
	logic         valid;
	logic         ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface : sample_stream_if

// file: src/secondary_audio_tx_slot_map.sv
// transmit slot mapping for the second audio port with wishbone registers
//
// Operation
// R1: offset zero places MSB per standard framing
// R2: offset N delays slot-zero MSB N bit clocks
// R3: channel select bit routes primary or secondary pin
// R4: channel 1 disabled means output tri-stated
// R5: TDM slot number selects slot 0 to 31
// R6: I2S/LJ values 16 up select right half
// R7: reserved upper bits read zero, write reset value; pin select stores and reads back its bits 7:1
// R8: framing codes TDM, I2S, LJ, reserved
// R9: slot length codes give 16/20/24/32 bits
// R10: software avoids two channels sharing one slot
//
// The implementer's own choice: the Wishbone interface to the registers.
`include "tx_slot_map.svh"

module secondary_audio_tx_slot_map #(
	parameter int SW         = 32,
	parameter int FIFO_DEPTH = 16
) (
	// clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	// wishbone slave
	input  wire logic          wb_cyc_i,
	input  wire logic          wb_stb_i,
	input  wire logic          wb_we_i,
	input  wire logic [7:0]    wb_adr_i,
	input  wire logic [3:0]    wb_sel_i,
	input  wire logic [31:0]   wb_dat_i,
	output logic      [31:0]   wb_dat_o,
	output logic               wb_ack_o,
	// converter channel 1 samples
	input  wire logic [SW-1:0] sample_data_i,
	input  wire logic          sample_valid_i,
	output logic               sample_ready_o,
	// serial link
	input  wire logic          bclk_i,
	input  wire logic          fsync_i,
	output logic               primary_data_out_o,
	output logic               primary_data_oe_n_o,
	output logic               secondary_data_out_o,
	output logic               secondary_data_oe_n_o
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [5:0] slot_len(input logic [1:0] code);
		case (code)
			2'h0:    slot_len = `SLOT_LEN_16; // [R9]
			2'h1:    slot_len = `SLOT_LEN_20; // [R9]
			2'h2:    slot_len = `SLOT_LEN_24; // [R9]
			default: slot_len = `SLOT_LEN_32; // [R9]
		endcase
	endfunction : slot_len

	function automatic logic slot_hit(input tx_slot_pkg::framing_t fmt,
			input logic [4:0] num, input logic half, input logic [4:0] slot);
		if (fmt == tx_slot_pkg::FMT_TDM) begin
			slot_hit = (slot == num); // [R5]
		end else begin
			slot_hit = (half == num[`SLOT_HALF_BIT]) && (slot == {1'b0, num[3:0]}); // [R6]
		end
	endfunction : slot_hit

	// ----------------------------------------
	// sample buffer
	// ----------------------------------------
	sample_stream_if #(.W(SW)) in_s ();
	sample_stream_if #(.W(SW)) out_s ();
	logic [$clog2(FIFO_DEPTH):0] level;
	logic                        pop;

	assign in_s.data      = sample_data_i;
	assign in_s.valid     = sample_valid_i;
	assign sample_ready_o = in_s.ready;
	assign out_s.ready    = pop;

	sample_fifo #(.W(SW), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.push    (in_s),
		.pop     (out_s),
		.level_o (level)
	);

	// ----------------------------------------
	// register bus
	// ----------------------------------------
	logic [7:0]  framing_r, framing_nxt, offset_r, offset_nxt;
	logic [7:0]  pin_sel_r, pin_sel_nxt, ch1_cfg_r, ch1_cfg_nxt;
	logic        underrun_r, underrun_nxt, underrun_set;
	logic        ack_r, ack_nxt;
	logic [31:0] dat_r, dat_nxt;
	logic        req, wr_hit;
	logic [5:0]  idx;
	tx_slot_pkg::link_state_t state_r, state_nxt;

	assign idx      = wb_adr_i[7:2];
	assign req      = wb_cyc_i && wb_stb_i && !ack_r;
	assign wr_hit   = req && wb_we_i && wb_sel_i[0];
	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	always_comb begin
		framing_nxt  = framing_r;
		offset_nxt   = offset_r;
		pin_sel_nxt  = pin_sel_r;
		ch1_cfg_nxt  = ch1_cfg_r;
		underrun_nxt = underrun_r;
		if (wr_hit) begin
			if (idx == `IDX_FRAMING) begin
				framing_nxt = {wb_dat_i[7:4], 4'h0};
			end else if (idx == `IDX_MSB_OFFSET) begin
				offset_nxt = {3'h0, wb_dat_i[4:0]}; // [R7]
			end else if (idx == `IDX_PIN_SELECT) begin
				pin_sel_nxt = wb_dat_i[7:0];
			end else if (idx == `IDX_CH1_CONFIG) begin
				ch1_cfg_nxt = {2'h0, wb_dat_i[5:0]}; // [R7]
			end else if (idx == `IDX_STATUS && wb_dat_i[`ST_UNDERRUN_BIT]) begin
				underrun_nxt = 1'b0;
			end
		end
		// a new underrun outranks a clear in the same cycle
		if (underrun_set) begin
			underrun_nxt = 1'b1;
		end
		dat_nxt = 32'h0000_0000;
		if (req && !wb_we_i) begin
			if (idx == `IDX_FRAMING) begin
				dat_nxt[7:0] = framing_r;
			end else if (idx == `IDX_MSB_OFFSET) begin
				dat_nxt[7:0] = offset_r;
			end else if (idx == `IDX_PIN_SELECT) begin
				dat_nxt[7:0] = pin_sel_r;
			end else if (idx == `IDX_CH1_CONFIG) begin
				dat_nxt[7:0] = ch1_cfg_r;
			end else if (idx == `IDX_STATUS) begin
				dat_nxt[`ST_RUN_BIT]      = (state_r == tx_slot_pkg::LINK_RUN);
				dat_nxt[`ST_UNDERRUN_BIT] = underrun_r;
				dat_nxt[7:`ST_LEVEL_LO]   = 5'(level);
			end
		end
		ack_nxt = req;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			framing_r  <= `RST_FRAMING;
			offset_r   <= `RST_MSB_OFFSET;
			pin_sel_r  <= `RST_PIN_SELECT;
			ch1_cfg_r  <= `RST_CH1_CONFIG;
			underrun_r <= 1'b0;
			ack_r      <= 1'b0;
			dat_r      <= 32'h0000_0000;
		end else begin
			framing_r  <= framing_nxt;
			offset_r   <= offset_nxt;
			pin_sel_r  <= pin_sel_nxt;
			ch1_cfg_r  <= ch1_cfg_nxt;
			underrun_r <= underrun_nxt;
			ack_r      <= ack_nxt;
			dat_r      <= dat_nxt;
		end
	end

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [2:0] bclk_s_r, fs_s_r;
	logic       bclk_lv_r, bclk_lv_nxt, fs_lv_r, fs_lv_nxt;
	logic       rise, fall;

	always_comb begin
		bclk_lv_nxt = (bclk_s_r[1] == bclk_s_r[2]) ? bclk_s_r[2] : bclk_lv_r;
		fs_lv_nxt   = (fs_s_r[1] == fs_s_r[2]) ? fs_s_r[2] : fs_lv_r;
		rise        = bclk_lv_nxt && !bclk_lv_r;
		fall        = !bclk_lv_nxt && bclk_lv_r;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bclk_s_r  <= 3'h0;
			fs_s_r    <= 3'h0;
			bclk_lv_r <= 1'b0;
			fs_lv_r   <= 1'b0;
		end else begin
			bclk_s_r  <= {bclk_s_r[1:0], bclk_i};
			fs_s_r    <= {fs_s_r[1:0], fsync_i};
			bclk_lv_r <= bclk_lv_nxt;
			fs_lv_r   <= fs_lv_nxt;
		end
	end

	// ----------------------------------------
	// link sequencer
	// ----------------------------------------
	tx_slot_pkg::framing_t fmt;
	logic [10:0]   pos_r, pos_nxt, len_r, len_nxt;
	logic          fs_prev_r, fs_prev_nxt, half_r, half_nxt;
	logic [4:0]    dly_r, dly_nxt, slot_r, slot_nxt;
	logic [5:0]    bit_r, bit_nxt, slen;
	logic [SW-1:0] shift_r, shift_nxt, sh;
	logic          act_r, act_nxt, out_r, out_nxt;
	logic          pri_oe_n_r, pri_oe_n_nxt, sec_oe_n_r, sec_oe_n_nxt;
	logic          frame_ev, launch, emit, en, route;

	assign fmt   = tx_slot_pkg::framing_t'(framing_r[`FRM_FMT_LO +: 2]);
	assign slen  = slot_len(framing_r[`FRM_WLEN_LO +: 2]);
	assign en    = ch1_cfg_r[`CH1_EN_BIT];
	assign route = pin_sel_r[0];

	always_comb begin
		state_nxt    = state_r;
		pos_nxt      = pos_r;
		len_nxt      = len_r;
		fs_prev_nxt  = fs_prev_r;
		half_nxt     = half_r;
		dly_nxt      = dly_r;
		slot_nxt     = slot_r;
		bit_nxt      = bit_r;
		shift_nxt    = shift_r;
		act_nxt      = act_r;
		out_nxt      = out_r;
		pop          = 1'b0;
		underrun_set = 1'b0;
		emit         = 1'b0;
		sh           = shift_r;
		frame_ev     = 1'b0;
		launch       = 1'b0;
		if (rise) begin
			// TDM frames start on the fsync rise, I2S and LJ halves on either edge
			frame_ev    = (fs_lv_r != fs_prev_r) && (fs_lv_r || fmt != tx_slot_pkg::FMT_TDM);
			fs_prev_nxt = fs_lv_r;
			pos_nxt     = frame_ev ? 11'h000 : pos_r + 11'h001;
			if (frame_ev && fmt != tx_slot_pkg::FMT_TDM) begin
				len_nxt = pos_r + 11'h001;
			end
			// LJ MSB sits on the fsync edge itself, so launch one bit early
			if (fmt == tx_slot_pkg::FMT_LJ) begin
				launch = !frame_ev && (len_r > 11'h001) && (pos_r + 11'h001 == len_r - 11'h001);
			end else if (fmt != tx_slot_pkg::FMT_RSV) begin
				launch = frame_ev; // [R8]
			end
			if (launch) begin
				state_nxt = tx_slot_pkg::LINK_DELAY;
				dly_nxt   = offset_r[4:0]; // [R1] [R2]
				half_nxt  = (fmt != tx_slot_pkg::FMT_TDM) && fs_lv_r;
				slot_nxt  = 5'h00;
				bit_nxt   = 6'h00;
				act_nxt   = 1'b0;
			end
		end
		if (fall) begin
			case (state_r)
				tx_slot_pkg::LINK_DELAY: begin
					if (dly_r == 5'h00) begin
						emit      = 1'b1;
						state_nxt = tx_slot_pkg::LINK_RUN;
					end else begin
						dly_nxt = dly_r - 5'h01; // [R2]
					end
				end
				tx_slot_pkg::LINK_RUN: begin
					emit = 1'b1;
				end
				default: begin
					act_nxt = 1'b0;
				end
			endcase
		end
		if (emit) begin
			if (bit_r == 6'h00) begin
				act_nxt = en && slot_hit(fmt, ch1_cfg_r[4:0], half_r, slot_r);
				if (act_nxt) begin
					pop          = out_s.valid;
					underrun_set = !out_s.valid;
					sh           = out_s.valid ? out_s.data : '0;
				end
			end
			out_nxt   = sh[SW-1];
			shift_nxt = sh << 1;
			if (bit_r == slen - 6'h01) begin
				bit_nxt = 6'h00; // [R9]
				if (slot_r == `LAST_SLOT) begin
					state_nxt = tx_slot_pkg::LINK_WAIT;
				end else begin
					slot_nxt = slot_r + 5'h01;
				end
			end else begin
				bit_nxt = bit_r + 6'h01;
			end
		end
		pri_oe_n_nxt = !(act_r && en && !route); // [R3] [R4]
		sec_oe_n_nxt = !(act_r && en && route);  // [R3] [R4]
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r    <= tx_slot_pkg::LINK_WAIT;
			pos_r      <= 11'h000;
			len_r      <= 11'h000;
			fs_prev_r  <= 1'b0;
			half_r     <= 1'b0;
			dly_r      <= 5'h00;
			slot_r     <= 5'h00;
			bit_r      <= 6'h00;
			shift_r    <= '0;
			act_r      <= 1'b0;
			out_r      <= 1'b0;
			pri_oe_n_r <= 1'b1;
			sec_oe_n_r <= 1'b1;
		end else begin
			state_r    <= state_nxt;
			pos_r      <= pos_nxt;
			len_r      <= len_nxt;
			fs_prev_r  <= fs_prev_nxt;
			half_r     <= half_nxt;
			dly_r      <= dly_nxt;
			slot_r     <= slot_nxt;
			bit_r      <= bit_nxt;
			shift_r    <= shift_nxt;
			act_r      <= act_nxt;
			out_r      <= out_nxt;
			pri_oe_n_r <= pri_oe_n_nxt;
			sec_oe_n_r <= sec_oe_n_nxt;
		end
	end

	assign primary_data_out_o    = out_r;
	assign secondary_data_out_o  = out_r;
	assign primary_data_oe_n_o   = pri_oe_n_r;
	assign secondary_data_oe_n_o = sec_oe_n_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_ack_single_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single cycle after request");
	a_reserved_read_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
		wb_ack_o && $past(idx) == `IDX_MSB_OFFSET |-> wb_dat_o[7:5] == 3'h0)
		else $error("reserved offset bits read nonzero");
	a_disabled_tristate: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
		!en |=> primary_data_oe_n_o && secondary_data_oe_n_o)
		else $error("disabled channel drives a pin");
	a_pin_route_sel: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
		!primary_data_oe_n_o || !secondary_data_oe_n_o
		|-> $past(route) == !secondary_data_oe_n_o && $past(act_r))
		else $error("channel driven on wrong pin");
	a_offset_load: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
		launch |=> state_r == tx_slot_pkg::LINK_DELAY && dly_r == $past(offset_r[4:0]))
		else $error("offset not loaded at launch");
	a_zero_offset_msb: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
		fall && state_r == tx_slot_pkg::LINK_DELAY && dly_r == 5'h00
		|=> state_r == tx_slot_pkg::LINK_RUN && bit_r == 6'h01)
		else $error("MSB not emitted when delay reached zero");
	a_slot_select: assert property (@(posedge clk_i) disable iff (rst_i) // [R5] [R6]
		$rose(act_r) |-> $past(slot_hit(fmt, ch1_cfg_r[4:0], half_r, slot_r) && en))
		else $error("channel active in an unassigned slot");
	a_reserved_format: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
		fmt == tx_slot_pkg::FMT_RSV |-> !launch)
		else $error("reserved framing started a frame");
	a_slot_length: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
		emit && bit_r == slen - 6'h01 |=> bit_r == 6'h00)
		else $error("slot length not honoured");
endmodule : secondary_audio_tx_slot_map

// file: src/tx_slot_map.svh
// register indices, field positions, reset values and slot lengths
`ifndef TX_SLOT_MAP_SVH
`define TX_SLOT_MAP_SVH

// ----------------------------------------
// word indices (byte address = index * 4)
// ----------------------------------------
`define IDX_FRAMING      6'h1A
`define IDX_MSB_OFFSET   6'h1C
`define IDX_PIN_SELECT   6'h1D
`define IDX_CH1_CONFIG   6'h1E
`define IDX_STATUS       6'h30

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_FRAMING      8'h30
`define RST_MSB_OFFSET   8'h00
`define RST_PIN_SELECT   8'h00
`define RST_CH1_CONFIG   8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define FRM_FMT_LO       6
`define FRM_WLEN_LO      4
`define CH1_EN_BIT       5
`define SLOT_HALF_BIT    4
`define ST_RUN_BIT       0
`define ST_UNDERRUN_BIT  1
`define ST_LEVEL_LO      3

// ----------------------------------------
// slot lengths in bit clocks
// ----------------------------------------
`define SLOT_LEN_16      6'h10
`define SLOT_LEN_20      6'h14
`define SLOT_LEN_24      6'h18
`define SLOT_LEN_32      6'h20
`define LAST_SLOT        5'h1F

`endif

// file: src/tx_slot_pkg.sv
// types shared by the slot mapping block
package tx_slot_pkg;
	typedef enum logic [1:0] {
		FMT_TDM = 2'b00,
		FMT_I2S = 2'b01,
		FMT_LJ  = 2'b10,
		FMT_RSV = 2'b11
	} framing_t;

	typedef enum logic [1:0] {
		LINK_WAIT  = 2'b00,
		LINK_DELAY = 2'b01,
		LINK_RUN   = 2'b10
	} link_state_t;
endpackage : tx_slot_pkg
